// [design/selftest_timing_pkg.sv]
// Constants for the self-test timing block: register map, field layout, timing.
// Assumes a 50 MHz core clock and a byte-wide register port from the serial front end.
package selftest_timing_pkg;
  // Register offsets
  localparam logic [7:0] IDLE_CFG_ADDR  = 8'h37;
  localparam logic [7:0] DEC_CFG_ADDR   = 8'h38;
  // Reset values
  localparam logic [4:0] IDLE_RESET     = 5'h00;
  localparam logic [3:0] DEC_RESET      = 4'h0;
  // Field positions
  localparam int         IDLE_LSB       = 0;
  localparam int         DEC_LSB        = 0;
  // Highest code with its own power of two; above it the count saturates
  localparam logic [3:0] DEC_MAX_CODE   = 4'hB;
  localparam logic [3:0] DEC_SAT_SHIFT  = 4'hC;
  // Clock and phase times
  localparam int         CLK_MHZ        = 50;
  localparam int         IDLE_BASE_NS   = 312500;  // 312.5 us
  localparam int         IDLE_STEP_NS   = 31250;   // 31.25 us
  localparam int         CLK_NS         = 1000 / CLK_MHZ;
  localparam int         IDLE_BASE_CYC  = IDLE_BASE_NS / CLK_NS;
  localparam int         IDLE_STEP_CYC  = IDLE_STEP_NS / CLK_NS;
  localparam int         CYC_W          = 16;
  localparam int         SAMP_W         = 13;
  // Run-sequence states
  typedef enum logic [1:0] {ST_OFF, SELFTEST_IDLE_STEPS_PH, ST_MEAS_PH} phase_t;
endpackage

// [design/accel_selftest_timing.sv]
// Self-test timing engine: idle/measurement phase sequencer and its two registers.
// Assumes a byte register port on the same clock; axis choice comes from sensor_config_one.
// What this block does
// [RQ1] Idle phase is 312.5us plus 31.25us per step
// [RQ2] Average two-to-code samples, codes 12-15 give 4096
// [RQ3] Minimum idle, one sample gives 3200 Hz
// [RQ4] Period equals samples times idle-phase duration
// [RQ5] Ignore user rate and power during self-test
// [RQ6] Axis choice 00b restores user rate, power
// [RQ7] Software sets fields before choosing an axis
`timescale 1ns/1ps
module accel_selftest_timing (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Register port
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // Self-test axis choice and user settings
  input  wire logic [1:0] i_selftest_axis_choice,
  input  wire logic [3:0] i_output_data_rate,
  input  wire logic [1:0] i_power_mode,
  // Timing outputs to the sensing path
  output logic      [3:0] o_output_data_rate,
  output logic      [1:0] o_power_mode,
  output logic            o_selftest_active,
  output logic            o_meas_phase,
  output logic            o_sample_tick,
  output logic            o_period_done
);
  // Whole state in one struct
  typedef struct packed {
    logic [4:0]                                  idle_q;     // Idle step field
    logic [3:0]                                  dec_q;      // Decimation code field
    logic [4:0]                                  run_idle_q; // Idle steps latched at start
    logic [3:0]                                  run_dec_q;  // Code latched at start
    selftest_timing_pkg::phase_t                 phase_q;    // Sequencer phase
    logic [selftest_timing_pkg::CYC_W-1:0]       cyc_q;      // Cycles left in the slot
    logic [selftest_timing_pkg::SAMP_W-1:0]      samp_q;     // Samples left in period
    logic                                        tick_q;     // Sample slot finished
    logic                                        done_q;     // Period finished
    logic [selftest_timing_pkg::CYC_W-1:0]       gap_q;      // Check helper, cycles since period end or measurement entry
    logic [7:0]                                  rdata_q;    // Read data
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   st_on;

  // Counter reload for an idle setting: cycles in 312.5us + n x 31.25us, less one
  // Summed in ns before the divide: one step is half a cycle short of whole,
  // so odd settings lose half a cycle instead of every step losing half a cycle.
  // The largest setting still fits the 16-bit counter.
  function automatic logic [selftest_timing_pkg::CYC_W-1:0] slot_cycles(input logic [4:0] n);
    slot_cycles = selftest_timing_pkg::CYC_W'((selftest_timing_pkg::IDLE_BASE_NS
                  + int'(n) * selftest_timing_pkg::IDLE_STEP_NS)
                  / selftest_timing_pkg::CLK_NS - 1); // RQ1
  endfunction

  // Samples per measurement phase, saturating at 4096
  function automatic logic [selftest_timing_pkg::SAMP_W-1:0] samples(input logic [3:0] c);
    logic [3:0] sh;
    sh = (c > selftest_timing_pkg::DEC_MAX_CODE) ? selftest_timing_pkg::DEC_SAT_SHIFT : c; // RQ2
    samples = selftest_timing_pkg::SAMP_W'(1) << sh;
  endfunction

  // Self-test engaged whenever an axis is chosen
  assign st_on = (i_selftest_axis_choice != 2'h0);

  // Next-state logic
  always_comb begin
    s_d        = s_q;
    s_d.tick_q = 1'b0;
    s_d.done_q = 1'b0;
    // Register writes; upper bits are not stored and read as zero
    if (i_reg_wr && i_reg_addr == selftest_timing_pkg::IDLE_CFG_ADDR) begin
      s_d.idle_q = i_reg_wdata[selftest_timing_pkg::IDLE_LSB +: 5];
    end else if (i_reg_wr && i_reg_addr == selftest_timing_pkg::DEC_CFG_ADDR) begin
      s_d.dec_q = i_reg_wdata[selftest_timing_pkg::DEC_LSB +: 4];
    end
    // Read mux, unmapped offsets read zero
    if (i_reg_addr == selftest_timing_pkg::IDLE_CFG_ADDR) begin
      s_d.rdata_q = {3'h0, s_q.idle_q};
    end else if (i_reg_addr == selftest_timing_pkg::DEC_CFG_ADDR) begin
      s_d.rdata_q = {4'h0, s_q.dec_q};
    end else begin
      s_d.rdata_q = 8'h00;
    end
    // Sequencer
    case (s_q.phase_q)
      selftest_timing_pkg::ST_OFF: begin
        // Fields sampled at start so mid-run writes cannot stretch a period
        if (st_on) begin // RQ7
          s_d.run_idle_q = s_q.idle_q;
          s_d.run_dec_q  = s_q.dec_q;
          s_d.cyc_q      = slot_cycles(s_q.idle_q);
          s_d.samp_q     = samples(s_q.dec_q);
          s_d.phase_q    = selftest_timing_pkg::SELFTEST_IDLE_STEPS_PH;
        end
      end
      selftest_timing_pkg::SELFTEST_IDLE_STEPS_PH: begin
        // One idle slot before the sample train
        if (!st_on) begin
          s_d.phase_q = selftest_timing_pkg::ST_OFF; // RQ6
        end else if (s_q.cyc_q == '0) begin
          s_d.cyc_q   = slot_cycles(s_q.run_idle_q);
          s_d.phase_q = selftest_timing_pkg::ST_MEAS_PH;
        end else begin
          s_d.cyc_q = s_q.cyc_q - 1'b1;
        end
      end
      selftest_timing_pkg::ST_MEAS_PH: begin
        // Each sample uses one slot, so period = samples x slot
        if (!st_on) begin
          s_d.phase_q = selftest_timing_pkg::ST_OFF; // RQ6
        end else if (s_q.cyc_q == '0) begin
          s_d.tick_q = 1'b1;
          s_d.cyc_q  = slot_cycles(s_q.run_idle_q);
          if (s_q.samp_q == selftest_timing_pkg::SAMP_W'(1)) begin
            s_d.done_q = 1'b1; // RQ4 RQ3
            s_d.samp_q = samples(s_q.run_dec_q);
          end else begin
            s_d.samp_q = s_q.samp_q - 1'b1;
          end
        end else begin
          s_d.cyc_q = s_q.cyc_q - 1'b1;
        end
      end
      default: s_d.phase_q = selftest_timing_pkg::ST_OFF;
    endcase
    // Check helper: cycles since the last period end or measurement entry.
    // Lets the period check count cycles instead of using a long delay.
    if (s_d.done_q) begin
      // Period ends here, start a new count
      s_d.gap_q = '0;
    end else if (s_q.phase_q == selftest_timing_pkg::SELFTEST_IDLE_STEPS_PH
                 && s_d.phase_q == selftest_timing_pkg::ST_MEAS_PH) begin
      // First measurement slot starts here
      s_d.gap_q = '0;
    end else if (s_q.gap_q != '1) begin
      // Saturate so a stalled run cannot wrap into a false match
      s_d.gap_q = s_q.gap_q + 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_q         <= '0;
      s_q.idle_q  <= selftest_timing_pkg::IDLE_RESET;
      s_q.dec_q   <= selftest_timing_pkg::DEC_RESET;
      s_q.phase_q <= selftest_timing_pkg::ST_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // User rate and power pass only while self-test is off
  assign o_output_data_rate = st_on ? 4'h0 : i_output_data_rate; // RQ5 RQ6
  assign o_power_mode       = st_on ? 2'h0 : i_power_mode;       // RQ5 RQ6
  assign o_selftest_active  = (s_q.phase_q != selftest_timing_pkg::ST_OFF);
  assign o_meas_phase       = (s_q.phase_q == selftest_timing_pkg::ST_MEAS_PH);
  assign o_sample_tick      = s_q.tick_q;
  assign o_period_done      = s_q.done_q;
  assign o_reg_rdata        = s_q.rdata_q;

  // Checks, all on the core clock; the assertions are quiet during reset, the covers are not
  // Slot counter reloads with every tick
  a_slot_reload: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_sample_tick |-> s_q.cyc_q == slot_cycles(s_q.run_idle_q)) // RQ1
    else $error("slot not reloaded to idle length");
  // Large codes never load more than 4096 samples
  a_samp_sat: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (s_q.phase_q == selftest_timing_pkg::SELFTEST_IDLE_STEPS_PH && s_q.run_dec_q >= 4'hC)
    |-> s_q.samp_q <= 13'h1000) // RQ2
    else $error("sample count above 4096");
  // Minimum settings: one slot of 0.3125 ms between period ends
  a_min_period: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RQ3
    (o_period_done && s_q.run_dec_q == 4'h0 && s_q.run_idle_q == 5'h00)
    |-> $past(s_q.gap_q)
        == selftest_timing_pkg::CYC_W'(selftest_timing_pkg::IDLE_BASE_CYC - 1))
    else $error("minimum period not 0.3125 ms");
  // Ticks at least 9 cycles apart, never bunched
  a_tick_gap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_sample_tick |=> !o_sample_tick [*8]) // RQ4
    else $error("sample ticks too close");
  // A period only ends on a sample
  a_done_tick: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_period_done |-> o_sample_tick) // RQ4
    else $error("period end without sample");
  // User settings hidden while an axis is chosen
  a_user_mask: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_on |-> o_output_data_rate == 4'h0 && o_power_mode == 2'h0) // RQ5
    else $error("user settings leak during self-test");
  // User settings pass again with no axis chosen
  a_user_back: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !st_on |-> o_output_data_rate == i_output_data_rate && o_power_mode == i_power_mode) // RQ6
    else $error("user settings not restored");
  // Sequencer stops one edge after the axis choice clears
  a_stop_seq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(st_on) |=> !o_selftest_active) // RQ6
    else $error("sequencer did not stop");
  // Code is copied at the start edge
  a_latch_start: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_selftest_active) |-> s_q.run_dec_q == $past(s_q.dec_q)) // RQ7
    else $error("code not latched at start");
  c_start: cover property (@(posedge i_clock) $rose(o_selftest_active));
  c_period: cover property (@(posedge i_clock) o_period_done);
  c_abort: cover property (@(posedge i_clock) o_meas_phase && !st_on);
  // Period end at the minimum settings
  c_min_period: cover property (@(posedge i_clock)
    o_period_done && s_q.run_dec_q == 4'h0 && s_q.run_idle_q == 5'h00);
endmodule

// [test/test_accel_selftest_timing.sv]
// Testbench for the self-test timing engine: registers, masking, slot timing.
// Assumes the package and design are compiled first; the bench drives every input port.
`timescale 1ns/1ps
module test_accel_selftest_timing;
  logic       i_clock;     // 50 MHz core clock
  logic       i_rst_n;     // Sync reset, active low
  logic       i_reg_wr;    // Write strobe
  logic [7:0] i_reg_addr;  // Register offset
  logic [7:0] i_reg_wdata; // Write data
  logic [1:0] i_axis;      // Self-test axis choice
  logic [3:0] i_odr;       // User output rate
  logic [1:0] i_pwr;       // User power mode
  logic [7:0] o_rdata;     // Read data
  logic [3:0] o_odr;       // Rate to sensing path
  logic [1:0] o_pwr;       // Power mode to sensing path
  logic       o_act;       // Sequencer running
  logic       o_meas;      // Measurement phase
  logic       o_tick;      // End of sample slot
  logic       o_done;      // End of period
  int         error_cnt;   // Mismatches seen
  int         n_tests;     // Comparisons made
  // Device under test, every input driven
  accel_selftest_timing DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_rdata),
    .i_selftest_axis_choice(i_axis), .i_output_data_rate(i_odr), .i_power_mode(i_pwr),
    .o_output_data_rate(o_odr), .o_power_mode(o_pwr), .o_selftest_active(o_act),
    .o_meas_phase(o_meas), .o_sample_tick(o_tick), .o_period_done(o_done));
  // Clock source
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) #1;
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_clock) #1;
    i_reg_wr = 1'b0;
  endtask
  // Read data is registered, so sample two edges after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock) #1;
    i_reg_addr = a;
    repeat (2) @(posedge i_clock);
    #1 chk(o_rdata, exp);
  endtask
  // Reset values, field widths, unmapped offsets
  task automatic t_regs();
    rd(8'h37, 8'h00);
    rd(8'h38, 8'h00);
    wr(8'h37, 8'hFF);
    wr(8'h38, 8'hFF);
    rd(8'h37, 8'h1F);
    rd(8'h38, 8'h0F);
    wr(8'h36, 8'hAA);
    rd(8'h36, 8'h00);
    rd(8'h37, 8'h1F);
  endtask
  // User settings hidden for every nonzero axis choice
  task automatic t_mask();
    i_odr = 4'hA;
    i_pwr = 2'h2;
    for (int k = 1; k < 4; k++) begin
      @(posedge i_clock) #1;
      i_axis = k[1:0];
      #1 chk({o_odr, o_pwr}, 6'h00);
      i_axis = 2'h0;
      #1 chk({o_odr, o_pwr}, 6'h2A);
    end
    repeat (3) @(posedge i_clock);
  endtask
  // Idle 2 gives 312.5 + 62.5 us = 18750 cycles a slot; code 1 gives two slots a period
  task automatic t_run();
    int n;
    int dones;
    wr(8'h37, 8'h02);
    wr(8'h38, 8'h01);
    @(posedge i_clock) #1;
    i_axis = 2'h2;
    @(posedge i_clock) #1;
    chk(o_act, 1'b1);
    n = 0;
    while (o_tick !== 1'b1 && n < 40000) begin
      @(posedge i_clock) #1;
      n++;
    end
    chk(n, 37500);
    dones = 0;
    n = 0;
    do begin
      @(posedge i_clock) #1;
      n++;
      dones += int'(o_done);
    end while (o_tick !== 1'b1 && n < 20000);
    chk(n, 18750);
    chk(dones, 1);
    chk(o_meas, 1'b1);
    chk({o_odr, o_pwr}, 6'h00);
    i_axis = 2'h0;
    @(posedge i_clock) #1;
    chk(o_act, 1'b0);
    chk({o_odr, o_pwr}, 6'h2A);
  endtask
  // Minimum settings: idle slot then one 15625-cycle slot to the first period end
  task automatic t_min();
    int n;
    wr(8'h37, 8'h00);
    wr(8'h38, 8'h00);
    @(posedge i_clock) #1;
    i_axis = 2'h1;
    n = 0;
    do begin
      @(posedge i_clock) #1;
      n++;
    end while (o_done !== 1'b1 && n < 40000);
    chk(n, 31251);
    chk(o_tick, 1'b1);
    i_axis = 2'h0;
    @(posedge i_clock) #1;
    chk(o_act, 1'b0);
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well past the 90k cycles the run needs
  initial begin
    #2500000;
    error_cnt++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {error_cnt, n_tests} = '0;
    {i_rst_n, i_reg_wr, i_reg_addr, i_reg_wdata, i_axis, i_odr, i_pwr} = '0;
    repeat (8) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    t_regs();
    t_mask();
    t_run();
    t_min();
    wrap_up();
  end
endmodule
